// ---- pkg/bssr_pkg.sv ----
// Package with the constants and carrier types of the battery system state registers.
package bssr_pkg;
   // Own slave address, alert-response address and the blocked charger address.
   localparam logic [6:0] SYS_ADDR = 7'h0A;
   localparam logic [6:0] ARA_ADDR = 7'h0C;
   localparam logic [7:0] CHARGER_ADDR8 = 8'h12;
   localparam logic [7:0] ARA_RETURN = 8'h14;

   // Command codes, slave side and master side.
   localparam logic [7:0] CMD_STATE = 8'h01;
   localparam logic [7:0] CMD_STATE_CONT = 8'h02;
   localparam logic [7:0] CMD_CHG_VOLTAGE = 8'h15;
   localparam logic [7:0] CMD_ALARM = 8'h16;

   // Field positions of the system-state word.
   localparam int SEL_LSB = 12;
   localparam int PWR_LSB = 8;
   localparam int CHG_LSB = 4;
   localparam int PRS_LSB = 0;

   // Field positions of the continuation word and of the battery alarm word.
   localparam int CONT_AC_BIT = 0;
   localparam int CONT_PNG_BIT = 1;
   localparam int CONT_CRS_BIT = 2;
   localparam int ALARM_OVER_CHARGED_BIT = 15;

   // Reset values.
   localparam logic [3:0] SEL_RESET = 4'h1;
   localparam logic [15:0] CHG_VOLTAGE_RESET = 16'h0000;

   // Decoded SMBus slave transaction from the protocol engine.
   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] cmd;
      logic write;
      logic [15:0] wdata;
   } bssr_req_t;

   // Answer to one transaction.
   typedef struct packed {
      logic ack;
      logic [15:0] data;
   } bssr_rsp_t;

   // Word read from a battery while acting as bus master.
   typedef struct packed {
      logic batt;
      logic [7:0] cmd;
      logic [15:0] data;
   } bssr_batt_rd_t;
endpackage

// ---- hdl/bssr_sync.sv ----
// Two-flip-flop synchroniser for a group of pin levels.
module bssr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_reg;

   // Each bit gets its own pair; the first stage feeds only the second.
   for (genvar g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge i_core_clk or posedge i_rst) begin
         if (i_rst) begin
            meta_reg[g] <= 1'b0;
            o_sync[g] <= 1'b0;
         end else begin
            meta_reg[g] <= i_async[g];
            o_sync[g] <= meta_reg[g];
         end
      end
   end
endmodule // bssr_sync

// ---- hdl/bssr_alert.sv ----
// Sticky alert request that drives the open-drain alert line.
module bssr_alert (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_event,
   input wire logic i_clear,
   output logic o_pending
);
   // A new event in the clearing cycle keeps the request, so no change is lost.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pending <= 1'b0;
      end else if (i_ce) begin
         if (i_event) begin
            o_pending <= 1'b1;
         end else if (i_clear) begin
            o_pending <= 1'b0;
         end
      end
   end
endmodule // bssr_alert

// ---- hdl/bssr_regs.sv ----
// Battery system state and continuation words with alert and battery-side inputs.
//
// Overview of operation
// - Recognised command with forbidden data is acknowledged but its data is discarded.
// - Command 01h reads and writes the four-nibble system-state word.
// - Battery insertion or removal raises the alert line.
// - AC connection or disconnection raises the alert line.
// - Autonomous power or charge changes update nibbles only, never the alert.
// - Selected battery reads 0001 or 0010 and resets to 0001.
// - Selection write takes effect only with exactly one low bit set.
// - Writes to power, charging and presence nibbles are ignored.
// - Power nibble: 0011 both, 0010 battery 2, 0001 battery 1, 0000 AC.
// - Charging nibble: one bit per charging battery, 0000 when none charges.
// - Presence nibble: bit 0 battery 1, bit 1 battery 2.
// - Command 02h reads the continuation word; host access to charger is blocked.
// - Any change of AC availability drives the alert line low.
// - Adapter_available bit follows the adapter-detect comparator.
// - Power-inadequate bit follows the low-power comparator.
// - Alert-response read at address 0001100 returns 14h.
// - Desired charge voltage is read with command 15h as unsigned millivolts.
// - A battery whose over-charged alarm is set is never charged.
module bssr_regs (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_req_valid,
   input wire bssr_pkg::bssr_req_t i_req,
   output bssr_pkg::bssr_rsp_t o_rsp,
   output logic o_rsp_valid,
   input wire logic i_batt_rd_valid,
   input wire bssr_pkg::bssr_batt_rd_t i_batt_rd,
   input wire logic [1:0] i_presence_pins,
   input wire logic i_adapter_detect_input,
   input wire logic i_low_power_comparator_input,
   input wire logic [1:0] i_power_source_req,
   input wire logic [1:0] i_charge_req,
   output logic [3:0] o_host_battery_select,
   output logic [1:0] o_charge_enable,
   output logic [15:0] o_charge_voltage_b1,
   output logic [15:0] o_charge_voltage_b2,
   input wire logic i_smbalert_n,
   output logic o_smbalert_n,
   output logic o_smbalert_n_oe
);
   logic [3:0] sync_levels;
   logic [1:0] presence_nibble_bits;
   logic adapter_available;
   logic power_not_good;
   logic [1:0] presence_prev_reg;
   logic adapter_prev_reg;
   logic [3:0] host_battery_select_reg;
   logic [1:0] power_source_reg;
   logic [1:0] charging_reg;
   logic [1:0] over_charged_reg;
   logic [15:0] charge_voltage_reg [2];
   logic alert_event;
   logic alert_clear;
   logic alert_pending;
   logic [15:0] state_word;
   logic [15:0] cont_word;
   logic is_ours;
   logic is_ara;
   logic is_charger;
   bssr_pkg::bssr_rsp_t rsp_next;

   // Tells whether a written selection value is one that may be stored.
   function automatic logic sel_value_ok(input logic [3:0] v);
      return (v == 4'h1) || (v == 4'h2);
   endfunction

   // The battery contacts and both comparators arrive straight from pins.
   bssr_sync #(
      .WIDTH(4)
   ) u_sync (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_async({i_low_power_comparator_input, i_adapter_detect_input, i_presence_pins}),
      .o_sync(sync_levels)
   );

   assign presence_nibble_bits = sync_levels[1:0];
   assign adapter_available = sync_levels[2];
   assign power_not_good = sync_levels[3];

   // Previous levels, used to see insertions, removals and AC changes.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         presence_prev_reg <= 2'h0;
         adapter_prev_reg <= 1'b0;
      end else if (i_ce) begin
         presence_prev_reg <= presence_nibble_bits;
         adapter_prev_reg <= adapter_available;
      end
   end

   // Only presence and AC changes alert; power and charge moves are left for polling.
   assign alert_event = (presence_nibble_bits != presence_prev_reg)
      || (adapter_available != adapter_prev_reg);

   // Address decode of the incoming transaction.
   assign is_ours = (i_req.addr == bssr_pkg::SYS_ADDR);
   assign is_ara = (i_req.addr == bssr_pkg::ARA_ADDR) && !i_req.write;
   assign is_charger = ({i_req.addr, 1'b0} == bssr_pkg::CHARGER_ADDR8);

   // The alert-response read only clears when we are the one holding the line.
   assign alert_clear = i_req_valid && is_ara && alert_pending;

   bssr_alert u_alert (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_event(alert_event),
      .i_clear(alert_clear),
      .o_pending(alert_pending)
   );

   // Open drain: only ever pull low, and only while an alert is pending.
   assign o_smbalert_n = 1'b0;
   assign o_smbalert_n_oe = alert_pending;

   // Host selection: stored only for a legal one-hot value, otherwise kept.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         host_battery_select_reg <= bssr_pkg::SEL_RESET;
      end else if (i_ce) begin
         if (i_req_valid && is_ours && i_req.write && i_req.cmd == bssr_pkg::CMD_STATE) begin
            if (sel_value_ok(i_req.wdata[bssr_pkg::SEL_LSB +: 4])) begin
               host_battery_select_reg <= i_req.wdata[bssr_pkg::SEL_LSB +: 4];
            end
         end
      end
   end

   // Battery-side words read as master: desired voltage and over-charged alarm.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         charge_voltage_reg[0] <= bssr_pkg::CHG_VOLTAGE_RESET;
         charge_voltage_reg[1] <= bssr_pkg::CHG_VOLTAGE_RESET;
         over_charged_reg <= 2'h0;
      end else if (i_ce) begin
         if (i_batt_rd_valid && i_batt_rd.cmd == bssr_pkg::CMD_CHG_VOLTAGE) begin
            charge_voltage_reg[i_batt_rd.batt] <= i_batt_rd.data;
         end
         if (i_batt_rd_valid && i_batt_rd.cmd == bssr_pkg::CMD_ALARM) begin
            over_charged_reg[i_batt_rd.batt] <=
               i_batt_rd.data[bssr_pkg::ALARM_OVER_CHARGED_BIT];
         end
         // A removed battery forgets its alarm so a fresh pack starts clean.
         for (int b = 0; b < 2; b++) begin
            if (!presence_nibble_bits[b]) begin
               over_charged_reg[b] <= 1'b0;
            end
         end
      end
   end

   // Status nibbles come only from the device's own logic, never from the host.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         power_source_reg <= 2'h0;
         charging_reg <= 2'h0;
      end else if (i_ce) begin
         power_source_reg <= i_power_source_req & presence_nibble_bits;
         charging_reg <= i_charge_req & presence_nibble_bits & ~over_charged_reg;
      end
   end

   // Word images; upper bits of each nibble are zero by encoding.
   assign state_word = {host_battery_select_reg, 2'h0, power_source_reg,
      2'h0, charging_reg, 2'h0, presence_nibble_bits};
   always_comb begin
      cont_word = 16'h0000;
      cont_word[bssr_pkg::CONT_AC_BIT] = adapter_available;
      cont_word[bssr_pkg::CONT_PNG_BIT] = power_not_good;
      cont_word[bssr_pkg::CONT_CRS_BIT] = 1'b1;
   end

   // Answer decode. Writes with illegal data still ack; the charger address never acks.
   always_comb begin
      rsp_next = '0;
      if (is_charger) begin
         rsp_next.ack = 1'b0;
      end else if (is_ara) begin
         rsp_next.ack = alert_pending;
         rsp_next.data = {8'h00, bssr_pkg::ARA_RETURN};
      end else if (is_ours && i_req.cmd == bssr_pkg::CMD_STATE) begin
         rsp_next.ack = 1'b1;
         rsp_next.data = i_req.write ? 16'h0000 : state_word;
      end else if (is_ours && i_req.cmd == bssr_pkg::CMD_STATE_CONT) begin
         rsp_next.ack = 1'b1;
         rsp_next.data = i_req.write ? 16'h0000 : cont_word;
      end else begin
         rsp_next.ack = 1'b0;
      end
   end

   // The answer is registered and stands until the next transaction.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rsp <= '0;
         o_rsp_valid <= 1'b0;
      end else if (i_ce) begin
         o_rsp_valid <= i_req_valid;
         if (i_req_valid) begin
            o_rsp <= rsp_next;
         end
      end
   end

   // Outputs to the host multiplexer and the charger.
   assign o_host_battery_select = host_battery_select_reg;
   assign o_charge_enable = charging_reg;
   assign o_charge_voltage_b1 = charge_voltage_reg[0];
   assign o_charge_voltage_b2 = charge_voltage_reg[1];
endmodule // bssr_regs

// ---- verification/bssr_regs_sva.sv ----
// Checker of the port behaviour of the battery system state registers.
module bssr_regs_sva (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_req_valid,
   input wire bssr_pkg::bssr_req_t i_req,
   input wire bssr_pkg::bssr_rsp_t o_rsp,
   input wire logic o_rsp_valid,
   input wire logic i_batt_rd_valid,
   input wire bssr_pkg::bssr_batt_rd_t i_batt_rd,
   input wire logic [1:0] i_presence_pins,
   input wire logic i_adapter_detect_input,
   input wire logic [3:0] o_host_battery_select,
   input wire logic [1:0] o_charge_enable,
   input wire logic [15:0] o_charge_voltage_b1,
   input wire logic o_smbalert_n_oe
);
   // Request classes shared by the properties, decoded once.
   wire logic take = i_ce && i_req_valid;
   wire logic ara_rd = take && i_req.addr == bssr_pkg::ARA_ADDR && !i_req.write;
   wire logic sel_wr = take && i_req.write && i_req.addr == bssr_pkg::SYS_ADDR
      && i_req.cmd == bssr_pkg::CMD_STATE;
   wire logic sel_ok = i_req.wdata[15:12] == 4'h1 || i_req.wdata[15:12] == 4'h2;
   wire logic brd = i_ce && i_batt_rd_valid && !i_batt_rd.batt;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   property p_rsp; take |=> o_rsp_valid; endproperty
   a_rsp: assert property (p_rsp) else $error("no answer after a request");
   property p_sel; o_host_battery_select == 4'h1 || o_host_battery_select == 4'h2; endproperty
   a_sel: assert property (p_sel) else $error("selection out of range");
   property p_bad_sel; sel_wr && !sel_ok |=> o_rsp.ack && $stable(o_host_battery_select); endproperty
   a_bad_sel: assert property (p_bad_sel) else $error("bad selection not ignored");
   property p_new_sel; sel_wr && sel_ok |=> o_host_battery_select == $past(i_req.wdata[15:12]);
   endproperty
   a_new_sel: assert property (p_new_sel) else $error("selection not taken");
   property p_charger; take && i_req.addr == 7'h09 |=> !o_rsp.ack; endproperty
   a_charger: assert property (p_charger) else $error("charger address answered");
   property p_ara; ara_rd && o_smbalert_n_oe |=> o_rsp.ack && o_rsp.data == 16'h0014; endproperty
   a_ara: assert property (p_ara) else $error("wrong alert response");
   property p_hold; o_smbalert_n_oe && !ara_rd |=> o_smbalert_n_oe; endproperty
   a_hold: assert property (p_hold) else $error("alert dropped early");
   property p_ac; $changed(i_adapter_detect_input) |-> ##[1:5] o_smbalert_n_oe; endproperty
   a_ac: assert property (p_ac) else $error("no alert on adapter change");
   property p_bat; $changed(i_presence_pins) |-> ##[1:5] o_smbalert_n_oe; endproperty
   a_bat: assert property (p_bat) else $error("no alert on battery change");
   property p_volt; brd && i_batt_rd.cmd == bssr_pkg::CMD_CHG_VOLTAGE
      |=> o_charge_voltage_b1 == $past(i_batt_rd.data); endproperty
   a_volt: assert property (p_volt) else $error("voltage not stored");
   property p_alarm; brd && i_batt_rd.cmd == bssr_pkg::CMD_ALARM && i_batt_rd.data[15]
      |-> ##2 !o_charge_enable[0]; endproperty
   a_alarm: assert property (p_alarm) else $error("charging despite alarm");
endmodule // bssr_regs_sva

bind bssr_regs bssr_regs_sva i_bssr_regs_sva (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
   .i_req_valid(i_req_valid), .i_req(i_req), .o_rsp(o_rsp), .o_rsp_valid(o_rsp_valid),
   .i_batt_rd_valid(i_batt_rd_valid), .i_batt_rd(i_batt_rd), .i_presence_pins(i_presence_pins),
   .i_adapter_detect_input(i_adapter_detect_input), .o_host_battery_select(o_host_battery_select),
   .o_charge_enable(o_charge_enable), .o_charge_voltage_b1(o_charge_voltage_b1),
   .o_smbalert_n_oe(o_smbalert_n_oe));

// ---- verification/bssr_batt_model.sv ----
// Model of the two batteries answering word reads made by the block as bus master.
module bssr_batt_model (
   input wire logic i_core_clk,
   output logic o_valid,
   output bssr_pkg::bssr_batt_rd_t o_rd
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_valid = 1'b0;
      o_rd = '0;
   end
   // A battery may answer late; once released the word is inverted so stale data never matches.
   task automatic send(input logic batt, input logic [7:0] cmd, input logic [15:0] data,
      input int slow);
      repeat (slow) @(negedge i_core_clk);
      @(negedge i_core_clk);
      o_rd = {batt, cmd, data};
      o_valid = 1'b1;
      @(negedge i_core_clk);
      o_valid = 1'b0;
      o_rd = ~o_rd;
   endtask
endmodule // bssr_batt_model

// ---- verification/bssr_regs_bench.sv ----
// Self-checking bench of the battery system state registers.
module bssr_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_req_valid = 1'b0;
   logic ce = 1'b1;
   logic o_rsp_valid, batt_valid, o_smbalert_n, o_smbalert_n_oe;
   logic ac = 1'b0;
   logic lowpwr = 1'b0;
   logic [1:0] pres = 2'h0, pwr_req = 2'h0, chg_req = 2'h0, o_charge_enable;
   logic [3:0] o_host_battery_select;
   logic [15:0] v1, v2;
   bssr_pkg::bssr_req_t i_req = '0;
   bssr_pkg::bssr_rsp_t o_rsp;
   bssr_pkg::bssr_batt_rd_t batt_rd;
   int miscompares = 0;
   int n_tests = 0;
   // Row: address, command, write, data, expected ack, expected data, data checked.
   logic [49:0] rows [11] = '{
      {7'h0A, 8'h01, 1'h0, 16'h0000, 1'h1, 16'h1213, 1'h1},
      {7'h0A, 8'h01, 1'h1, 16'h2FFF, 1'h1, 16'h0000, 1'h0},
      {7'h0A, 8'h01, 1'h0, 16'h0000, 1'h1, 16'h2213, 1'h1},
      {7'h0A, 8'h01, 1'h1, 16'h3000, 1'h1, 16'h0000, 1'h0},
      {7'h0A, 8'h01, 1'h1, 16'h5000, 1'h1, 16'h0000, 1'h0},
      {7'h0A, 8'h01, 1'h0, 16'h0000, 1'h1, 16'h2213, 1'h1},
      {7'h0A, 8'h02, 1'h0, 16'h0000, 1'h1, 16'h0007, 1'h1},
      {7'h0A, 8'h02, 1'h1, 16'hFFFF, 1'h1, 16'h0000, 1'h0},
      {7'h0A, 8'h02, 1'h0, 16'h0000, 1'h1, 16'h0007, 1'h1},
      {7'h09, 8'h01, 1'h0, 16'h0000, 1'h0, 16'h0000, 1'h0},
      {7'h0C, 8'h00, 1'h0, 16'h0000, 1'h0, 16'h0000, 1'h0}};
   localparam logic [49:0] ARA = {7'h0C, 8'h00, 1'h0, 16'h0000, 1'h1, 16'h0014, 1'h1};
   // The alert wire has a pull-up, so it is high whenever nobody pulls it.
   wire logic alert_wire = o_smbalert_n_oe ? o_smbalert_n : 1'b1;
   always #10 i_core_clk = ~i_core_clk;
   bssr_regs i_bssr_regs (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(ce),
      .i_req_valid(i_req_valid), .i_req(i_req), .o_rsp(o_rsp), .o_rsp_valid(o_rsp_valid),
      .i_batt_rd_valid(batt_valid), .i_batt_rd(batt_rd), .i_presence_pins(pres),
      .i_adapter_detect_input(ac), .i_low_power_comparator_input(lowpwr),
      .i_power_source_req(pwr_req), .i_charge_req(chg_req),
      .o_host_battery_select(o_host_battery_select), .o_charge_enable(o_charge_enable),
      .o_charge_voltage_b1(v1), .o_charge_voltage_b2(v2), .i_smbalert_n(alert_wire),
      .o_smbalert_n(o_smbalert_n), .o_smbalert_n_oe(o_smbalert_n_oe));
   bssr_batt_model i_bssr_batt_model (.i_core_clk(i_core_clk), .o_valid(batt_valid),
      .o_rd(batt_rd));
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Requests go back to back; each answer is checked in the cycle it stands.
   task automatic run(input int n, input logic [49:0] r [11]);
      for (int k = 0; k <= n; k++) begin
         @(negedge i_core_clk);
         if (k > 0) chk({o_rsp_valid, o_rsp.ack, r[k-1][0] ? o_rsp.data : r[k-1][16:1]},
            {1'b1, r[k-1][17:1]});
         i_req_valid = (k < n);
         if (k < n) i_req = r[k][49:18];
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d, miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge i_core_clk);
      miscompares++;
      summarize();
   end
   initial begin
      repeat (2) @(negedge i_core_clk);
      chk({11'h0, o_smbalert_n_oe, o_host_battery_select, o_charge_enable}, 18'h4);
      i_rst = 1'b0;
      @(negedge i_core_clk);
      pres = 2'h3;
      ac = 1'b1;
      lowpwr = 1'b1;
      repeat (5) @(negedge i_core_clk);
      chk({16'h0, o_smbalert_n_oe, alert_wire}, 18'h2);
      repeat (8) @(negedge i_core_clk);
      chk({16'h0, o_smbalert_n_oe, alert_wire}, 18'h2);
      run(1, '{ARA, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0});
      chk({16'h0, o_smbalert_n_oe, alert_wire}, 18'h1);
      pwr_req = 2'h2;
      chg_req = 2'h1;
      repeat (6) @(negedge i_core_clk);
      chk({16'h0, o_smbalert_n_oe, alert_wire}, 18'h1);
      run(11, rows);
      // With the clock enable low a selection write must neither land nor be answered.
      @(negedge i_core_clk);
      ce = 1'b0;
      i_req_valid = 1'b1;
      i_req = {7'h0A, 8'h01, 1'h1, 16'h1000};
      @(negedge i_core_clk);
      chk({13'h0, o_rsp_valid, o_host_battery_select}, 18'h2);
      i_req_valid = 1'b0;
      ce = 1'b1;
      @(negedge i_core_clk);
      chk({13'h0, o_rsp_valid, o_host_battery_select}, 18'h2);
      // Dropping the low-power comparator must clear its bit; an unknown command gets no ack.
      lowpwr = 1'b0;
      repeat (3) @(negedge i_core_clk);
      run(2, '{{7'h0A, 8'h02, 1'h0, 16'h0000, 1'h1, 16'h0005, 1'h1},
         {7'h0A, 8'h3C, 1'h0, 16'h0000, 1'h0, 16'h0000, 1'h0},
         '0, '0, '0, '0, '0, '0, '0, '0, '0});
      chg_req = 2'h3;
      i_bssr_batt_model.send(1'h0, 8'h15, 16'h3070, 0);
      chk({2'h0, v1}, 18'h3070);
      i_bssr_batt_model.send(1'h1, 8'h15, 16'hBB80, 3);
      chk({2'h0, v2}, 18'hBB80);
      i_bssr_batt_model.send(1'h0, 8'h09, 16'h1234, 1);
      chk({v1, o_charge_enable}, {16'h3070, 2'h3});
      i_bssr_batt_model.send(1'h0, 8'h16, 16'h8000, 0);
      @(negedge i_core_clk);
      chk({16'h0, o_charge_enable}, 18'h2);
      pres = 2'h1;
      repeat (5) @(negedge i_core_clk);
      chk({16'h0, o_smbalert_n_oe, alert_wire}, 18'h2);
      summarize();
   end
endmodule // bssr_regs_bench
